// ==== rtl/sra_pkg.sv ====
// Constants shared by the segment reassembly controller
package sra_pkg;
    // ------------------------------------------------------------
    // Segment kinds as carried on the segment input
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRA_SEG_CONT = 2'b00,
        SRA_SEG_END = 2'b01,
        SRA_SEG_BEGIN = 2'b10,
        SRA_SEG_SINGLE = 2'b11
    } sra_seg_type;

    // ------------------------------------------------------------
    // Widths and reserved values
    // ------------------------------------------------------------
    localparam int TAG_W = 10;
    localparam logic [TAG_W-1:0] TAG_RSVD = 10'h000;
    localparam int SEQ_W = 4;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DROPS = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;

    // ------------------------------------------------------------
    // Reassembly timer, context count and channel width
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TMR_TIME_MS = 100;
    localparam int unsigned TMR_CYC = (TMR_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned CTX_NUM = 4;
    localparam int unsigned VCI_WIDTH = 8;
endpackage

// ==== rtl/sra_reassembly.sv ====
// Segment reassembly controller: per channel/tag contexts, sequence check, timer, status report
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sra_reassembly #(
    parameter int unsigned P_CTX_NUM = sra_pkg::CTX_NUM,
    parameter int unsigned P_VCI_W = sra_pkg::VCI_WIDTH,
    parameter int unsigned P_TMR_CYC = sra_pkg::TMR_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_seg_valid,
    input wire logic [1:0] i_seg_type,
    input wire logic [P_VCI_W-1:0] i_seg_vci,
    input wire logic [sra_pkg::TAG_W-1:0] i_seg_tag,
    input wire logic [sra_pkg::SEQ_W-1:0] i_seg_seq,
    input wire logic i_seg_crc_ok,
    input wire logic i_seg_da_match,
    input wire logic i_seg_da_indiv,
    input wire logic i_seg_bus,
    input wire logic [sra_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_single,
    output logic o_start,
    output logic o_append,
    output logic o_deliver,
    output logic o_discard,
    output logic [$clog2(P_CTX_NUM)-1:0] o_ctx,
    output logic [P_CTX_NUM-1:0] o_expired,
    output logic o_status_a,
    output logic o_status_b
);
    import sra_pkg::*;

    localparam int IDX_W = $clog2(P_CTX_NUM);
    localparam int TMR_W = $clog2(P_TMR_CYC + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(P_TMR_CYC - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [P_CTX_NUM-1:0] act;
        logic [P_CTX_NUM-1:0] ind;
        logic [P_CTX_NUM-1:0][P_VCI_W-1:0] virtual_channel_id;
        logic [P_CTX_NUM-1:0][TAG_W-1:0] tag;
        logic [P_CTX_NUM-1:0][SEQ_W-1:0] seq;
        logic [P_CTX_NUM-1:0][TMR_W-1:0] tmr;
        logic en;
        logic [CNT_W-1:0] drops;
        logic [31:0] rdata;
        logic single;
        logic start;
        logic append;
        logic deliver;
        logic discard;
        logic [IDX_W-1:0] ctx;
        logic [P_CTX_NUM-1:0] expired;
        logic sta;
        logic stb;
    } sra_state_type;

    sra_state_type st_reg;
    sra_state_type st_next;
    logic seg_ok;
    logic hit;
    logic [P_CTX_NUM-1:0] key_hit;
    logic [IDX_W-1:0] hidx;
    logic free;
    logic [IDX_W-1:0] fidx;
    logic rep;
    logic drop;

    // Modulo-16 successor of a sequence value
    function automatic logic [SEQ_W-1:0] seq_inc(input logic [SEQ_W-1:0] v);
        seq_inc = SEQ_W'(v + 4'h1);
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.single = 1'b0;
        st_next.start = 1'b0;
        st_next.append = 1'b0;
        st_next.deliver = 1'b0;
        st_next.discard = 1'b0;
        st_next.expired = '0;
        st_next.sta = 1'b0;
        st_next.stb = 1'b0;
        st_next.rdata = 32'h0000_0000;
        rep = 1'b0;
        drop = 1'b0;
        // Failed checks and the reserved tag never reach a context
        seg_ok = i_seg_valid && i_seg_crc_ok && st_reg.en && (i_seg_tag != TAG_RSVD);
        // Lookup on the full channel/tag key
        hit = 1'b0;
        hidx = '0;
        key_hit = '0;
        for (int i = 0; i < int'(P_CTX_NUM); i++) begin
            key_hit[i] = st_reg.act[i] && st_reg.virtual_channel_id[i] == i_seg_vci && st_reg.tag[i] == i_seg_tag;
            if (key_hit[i] && !hit) begin
                hit = 1'b1;
                hidx = IDX_W'(i);
            end
        end
        // Lowest idle context is the one handed out
        free = 1'b0;
        fidx = '0;
        for (int i = int'(P_CTX_NUM) - 1; i >= 0; i--) begin
            if (!st_reg.act[i]) begin
                free = 1'b1;
                fidx = IDX_W'(i);
            end
        end
        // Independent timers, one per active context
        for (int i = 0; i < int'(P_CTX_NUM); i++) begin
            if (st_reg.act[i]) begin
                if (st_reg.tmr[i] == TMR_LAST) begin
                    st_next.act[i] = 1'b0;
                    st_next.tmr[i] = '0;
                    st_next.expired[i] = 1'b1;
                end else begin
                    st_next.tmr[i] = TMR_W'(st_reg.tmr[i] + 1'b1);
                end
            end
        end
        // Segment handling; a hit beats a timer expiring in the same cycle
        if (seg_ok) begin
            if (i_seg_type == SRA_SEG_SINGLE) begin
                st_next.single = 1'b1;
            end else if (hit) begin
                st_next.ctx = hidx;
                st_next.expired[hidx] = 1'b0;
                st_next.act[hidx] = 1'b1;
                if (i_seg_type == SRA_SEG_BEGIN) begin
                    if (i_seg_da_match) begin
                        st_next.discard = 1'b1;
                        st_next.start = 1'b1;
                        st_next.tmr[hidx] = '0;
                        st_next.seq[hidx] = seq_inc(i_seg_seq);
                        st_next.ind[hidx] = i_seg_da_indiv;
                        rep = i_seg_da_indiv;
                        drop = 1'b1;
                    end
                end else if (i_seg_seq == st_reg.seq[hidx]) begin
                    st_next.append = 1'b1;
                    rep = st_reg.ind[hidx];
                    if (i_seg_type == SRA_SEG_CONT) begin
                        st_next.seq[hidx] = seq_inc(st_reg.seq[hidx]);
                    end else begin
                        st_next.deliver = 1'b1;
                        st_next.act[hidx] = 1'b0;
                        st_next.tmr[hidx] = '0;
                    end
                end else begin
                    // Early end of the unit, nothing delivered
                    st_next.discard = 1'b1;
                    st_next.act[hidx] = 1'b0;
                    st_next.tmr[hidx] = '0;
                    rep = st_reg.ind[hidx];
                    drop = 1'b1;
                end
            end else if (i_seg_type == SRA_SEG_BEGIN) begin
                if (i_seg_da_match && free) begin
                    st_next.start = 1'b1;
                    st_next.ctx = fidx;
                    st_next.act[fidx] = 1'b1;
                    st_next.virtual_channel_id[fidx] = i_seg_vci;
                    st_next.tag[fidx] = i_seg_tag;
                    st_next.tmr[fidx] = '0;
                    st_next.seq[fidx] = seq_inc(i_seg_seq);
                    st_next.ind[fidx] = i_seg_da_indiv;
                    rep = i_seg_da_indiv;
                end else if (i_seg_da_match) begin
                    // No room: drop silently, the optional report is not given
                    st_next.discard = 1'b1;
                    drop = 1'b1;
                end
                // No destination match: ignored entirely
            end else begin
                st_next.discard = 1'b1;
                drop = 1'b1;
            end
        end
        // Report on the arrival bus only
        st_next.sta = rep && !i_seg_bus;
        st_next.stb = rep && i_seg_bus;
        // Register writes; a drop in the clearing cycle still counts
        if (i_wr && i_addr == REG_CTRL) begin
            st_next.en = i_wdata[CTRL_EN_BIT];
        end
        if (i_wr && i_addr == REG_DROPS) begin
            st_next.drops = CNT_W'(drop);
        end else if (drop) begin
            st_next.drops = CNT_W'(st_reg.drops + 1'b1);
        end
        // Read data valid the cycle after the strobe, zero otherwise
        if (i_rd) begin
            case (i_addr)
                REG_CTRL: st_next.rdata = 32'(st_reg.en);
                REG_ACTIVE: st_next.rdata = 32'(st_reg.act);
                REG_DROPS: st_next.rdata = 32'(st_reg.drops);
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.en <= CTRL_EN_RST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign o_rdata = st_reg.rdata;
    assign o_single = st_reg.single;
    assign o_start = st_reg.start;
    assign o_append = st_reg.append;
    assign o_deliver = st_reg.deliver;
    assign o_discard = st_reg.discard;
    assign o_ctx = st_reg.ctx;
    assign o_expired = st_reg.expired;
    assign o_status_a = st_reg.sta;
    assign o_status_b = st_reg.stb;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // A failed payload check must leave every context untouched
    crc_gate_a: assert property (i_ce && i_seg_valid && !i_seg_crc_ok
        |=> !(o_start || o_append || o_deliver || o_discard || o_single))
        else $error("failed segment changed a context");

    // A disabled block ignores even clean segments
    enable_gate_a: assert property (i_ce && i_seg_valid && !st_reg.en
        |=> !(o_start || o_append || o_deliver || o_discard || o_single))
        else $error("segment handled while disabled");

    // The reserved tag never opens or feeds a context
    rsvd_tag_a: assert property (i_ce && i_seg_valid && i_seg_tag == TAG_RSVD
        |=> !(o_start || o_append || o_deliver || o_discard || o_single))
        else $error("reserved tag reached a context");

    // Two live contexts on one key would split a unit in two
    key_unique_a: assert property (i_ce && seg_ok |-> $onehot0(key_hit))
        else $error("channel and tag matched more than one context");

    // Low clock enable holds every state bit, timers included
    ce_freeze_a: assert property (!i_ce |=> $stable(st_reg))
        else $error("state moved while clock enable was low");

    // ------------------------------------------------------------
    // Assertions: opening and refusing a context
    // ------------------------------------------------------------
    // Single segments bypass the contexts
    single_direct_a: assert property (i_ce && seg_ok && i_seg_type == SRA_SEG_SINGLE
        |=> o_single && !o_start && !o_append)
        else $error("single segment not delivered directly");

    // A fresh or restarted context expects the next sequence value
    start_seq_a: assert property (i_ce && seg_ok && i_seg_type == SRA_SEG_BEGIN && i_seg_da_match
        ##0 (hit || free) |=> o_start && st_reg.seq[o_ctx] == $past(i_seg_seq) + 4'h1)
        else $error("begin did not load sequence plus one");

    // Flag and report both follow the destination kind
    indiv_report_a: assert property (i_ce && seg_ok && !hit && free && i_seg_type == SRA_SEG_BEGIN
        && i_seg_da_match |=> o_start && st_reg.ind[o_ctx] == $past(i_seg_da_indiv)
        && (o_status_a || o_status_b) == $past(i_seg_da_indiv))
        else $error("begin flag or report wrong");

    // Without a free context the begin is dropped without a report
    full_drop_a: assert property (i_ce && seg_ok && !hit && !free && i_seg_type == SRA_SEG_BEGIN
        && i_seg_da_match |=> o_discard && !o_start && !o_status_a && !o_status_b)
        else $error("begin without resources not dropped");

    // A begin for another node on a key with no live context changes nothing
    foreign_begin_a: assert property (i_ce && seg_ok && !hit && i_seg_type == SRA_SEG_BEGIN
        && !i_seg_da_match |=> !(o_start || o_discard || o_status_a || o_status_b))
        else $error("foreign begin touched a context");

    // Continue or end with no live context is thrown away
    idle_drop_a: assert property (i_ce && seg_ok && !hit && i_seg_type inside {SRA_SEG_CONT, SRA_SEG_END}
        |=> o_discard && !o_append && !o_start)
        else $error("idle continue or end not discarded");

    // ------------------------------------------------------------
    // Assertions: live contexts
    // ------------------------------------------------------------
    // In-order continue appends and advances the expected value
    cont_bump_a: assert property (i_ce && seg_ok && hit && i_seg_type == SRA_SEG_CONT
        && i_seg_seq == st_reg.seq[hidx] |=> o_append && !o_deliver && st_reg.act[o_ctx]
        && st_reg.seq[o_ctx] == $past(i_seg_seq) + 4'h1)
        else $error("continue did not advance the sequence");

    // In-order end delivers and frees the context
    end_deliver_a: assert property (i_ce && seg_ok && hit && i_seg_type == SRA_SEG_END
        && i_seg_seq == st_reg.seq[hidx] |=> o_append && o_deliver && !st_reg.act[o_ctx])
        else $error("end did not deliver the unit");

    // A delivered unit leaves its context idle
    deliver_idle_a: assert property (o_deliver |-> o_append && !st_reg.act[o_ctx])
        else $error("delivered context still active");

    // Restart keeps the context live with a fresh timer
    restart_keep_a: assert property (i_ce && seg_ok && hit && i_seg_type == SRA_SEG_BEGIN
        && i_seg_da_match |=> o_start && o_discard && st_reg.act[o_ctx] && st_reg.tmr[o_ctx] == '0)
        else $error("restart did not reload the context");

    // Out-of-order continue or end ends the unit; single segments never count here
    mismatch_end_a: assert property (i_ce && seg_ok && hit && i_seg_type inside {SRA_SEG_CONT, SRA_SEG_END}
        && i_seg_seq != st_reg.seq[hidx] |=> o_discard && !st_reg.act[o_ctx] && !o_append)
        else $error("mismatch did not end reassembly");

    // Group units stay silent on the status lines
    group_quiet_a: assert property (i_ce && seg_ok && hit && !st_reg.ind[hidx] && i_seg_type != SRA_SEG_BEGIN
        |=> !o_status_a && !o_status_b)
        else $error("group unit raised a status report");

    // Report only on the arrival bus; skipped after a frozen cycle
    status_bus_a: assert property ((o_status_a || o_status_b) && $past(i_ce)
        |-> o_status_b == $past(i_seg_bus) && !(o_status_a && o_status_b))
        else $error("status on wrong bus");

    // Expiry idles the context; context 0 stands for the others, which share the code
    expire_idle_a: assert property ($past(i_ce) && o_expired[0] |-> !st_reg.act[0] && $past(st_reg.act[0]))
        else $error("expired context not returned to idle");

    // Main scenarios
    single_c: cover property (o_single);
    start_c: cover property (o_start ##[1:20] o_deliver);
    expire_c: cover property (o_expired != '0);
    restart_c: cover property (o_start && o_discard);
    full_c: cover property (o_discard && st_reg.act == '1);
endmodule

`default_nettype wire

// ==== tb/sra_seg_src.sv ====
// Partner model: receive and validity path feeding segments into the controller
`timescale 1ns/1ps
`default_nettype none

module sra_seg_src (
    input wire logic i_clk,
    output logic o_valid,
    output logic [1:0] o_type,
    output logic [7:0] o_vci,
    output logic [sra_pkg::TAG_W-1:0] o_tag,
    output logic [sra_pkg::SEQ_W-1:0] o_seq,
    output logic [3:0] o_flags
);
    import sra_pkg::*;
    // ----------------------------------------
    // Idle lines
    // ----------------------------------------
    initial begin
        o_valid = 1'b0;
        o_type = 2'h0;
        o_vci = 8'h00;
        o_tag = 10'h000;
        o_seq = 4'h0;
        o_flags = 4'h0;
    end
    // One segment per call, held for exactly one edge; flags are {crc_ok, da_match, da_indiv, bus}
    // Released lines show inverted values so a stale sample never looks valid
    task automatic send(input logic [1:0] t, input logic [7:0] v, input logic [9:0] g, input logic [3:0] s,
                        input logic [3:0] f);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_type <= t;
        o_vci <= v;
        o_tag <= g;
        o_seq <= s;
        o_flags <= f;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_type <= ~t;
        o_vci <= ~v;
        o_tag <= ~g;
        o_seq <= ~s;
        o_flags <= ~f;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the segment reassembly controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sra_pkg::*;
    // Short timer so expiry fits in the run
    localparam int unsigned TMR = 20;
    localparam logic [1:0] K_C = SRA_SEG_CONT;
    localparam logic [1:0] K_E = SRA_SEG_END;
    localparam logic [1:0] K_B = SRA_SEG_BEGIN;
    localparam logic [1:0] K_S = SRA_SEG_SINGLE;
    logic clk, nrst, ce, wr, rd, sv, single, start, app, dlv, disc, sa, sb;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] st, ctx;
    logic [7:0] virtual_channel_id;
    logic [TAG_W-1:0] tag;
    logic [SEQ_W-1:0] seq;
    logic [3:0] fl, expd;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_exp = 0;

    sra_seg_src pm (.i_clk(clk), .o_valid(sv), .o_type(st), .o_vci(virtual_channel_id), .o_tag(tag), .o_seq(seq), .o_flags(fl));
    sra_reassembly #(.P_TMR_CYC(TMR)) dut (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_seg_valid(sv),
        .i_seg_type(st), .i_seg_vci(virtual_channel_id), .i_seg_tag(tag), .i_seg_seq(seq), .i_seg_crc_ok(fl[3]),
        .i_seg_da_match(fl[2]), .i_seg_da_indiv(fl[1]), .i_seg_bus(fl[0]), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_single(single), .o_start(start), .o_append(app),
        .o_deliver(dlv), .o_discard(disc), .o_ctx(ctx), .o_expired(expd), .o_status_a(sa), .o_status_b(sb));

    // ----------------------------------------
    // Clock, expiry tally and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_exp <= n_exp + $countones(expd);
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdata, exp);
    endtask
    // Outputs {single,start,append,deliver,discard,status_a,status_b}; c < 0 skips the index
    task automatic seg(input logic [1:0] t, input logic [7:0] v, input logic [9:0] g, input logic [3:0] s,
                       input logic [3:0] f, input logic [6:0] e, input int c, input logic [6:0] m = 7'h7F);
        pm.send(t, v, g, s, f);
        #1 cmp({25'h0, {single, start, app, dlv, disc, sa, sb} & m}, {25'h0, e});
        if (c >= 0) cmp({30'h0, ctx}, c);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(REG_CTRL, 32'h1);
        rd_reg(REG_ACTIVE, 32'h0);
        rd_reg(REG_DROPS, 32'h0);
        rd_reg(8'h0C, 32'h0);
        // A write under a low clock enable must not land
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(REG_CTRL, 32'h0);
        ce <= 1'b1;
        rd_reg(REG_CTRL, 32'h1);
        seg(K_S, 8'h01, 10'h005, 4'h0, 4'hE, 7'h40, -1);
        seg(K_B, 8'h01, 10'h005, 4'hF, 4'hE, 7'h22, 0);
        seg(K_C, 8'h01, 10'h005, 4'h0, 4'hF, 7'h11, 0);
        seg(K_B, 8'h02, 10'h005, 4'h3, 4'hC, 7'h20, 1);
        seg(K_C, 8'h02, 10'h005, 4'h7, 4'hC, 7'h04, 1);
        rd_reg(REG_ACTIVE, 32'h1);
        seg(K_E, 8'h01, 10'h005, 4'h1, 4'hE, 7'h1A, 0);
        rd_reg(REG_ACTIVE, 32'h0);
        seg(K_B, 8'h01, 10'h006, 4'h0, 4'h6, 7'h00, -1);
        seg(K_B, 8'h01, 10'h000, 4'h0, 4'hE, 7'h00, -1);
        seg(K_B, 8'h01, 10'h006, 4'h0, 4'hA, 7'h00, -1);
        wr_reg(REG_CTRL, 32'h0);
        seg(K_B, 8'h01, 10'h006, 4'h0, 4'hE, 7'h00, -1);
        wr_reg(REG_CTRL, 32'h1);
        wr_reg(8'h0C, 32'h0);
        rd_reg(REG_CTRL, 32'h1);
        seg(K_C, 8'h03, 10'h009, 4'hA, 4'hE, 7'h04, -1);
        rd_reg(REG_ACTIVE, 32'h0);
        wr_reg(REG_DROPS, 32'h0);
        seg(K_B, 8'h03, 10'h009, 4'h2, 4'hF, 7'h21, 0);
        seg(K_B, 8'h03, 10'h009, 4'h8, 4'hC, 7'h24, 0);
        seg(K_C, 8'h03, 10'h009, 4'h9, 4'hE, 7'h10, 0);
        rd_reg(REG_DROPS, 32'h1);
        wr_reg(REG_DROPS, 32'h5);
        rd_reg(REG_DROPS, 32'h0);
        for (int k = 1; k < 4; k++) begin
            seg(K_B, 8'h04, k[9:0], 4'h0, 4'hE, 7'h22, k);
        end
        seg(K_B, 8'h04, 10'h004, 4'h0, 4'hE, 7'h04, -1);
        rd_reg(REG_ACTIVE, 32'hF);
        repeat (TMR + 10) @(posedge clk);
        #1 cmp(n_exp, 32'd4);
        rd_reg(REG_ACTIVE, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
